// ===== common/sps_pkg.sv
// Package: shared scaler and external count synchroniser constants and types
package sps_pkg;

	// ------------------------------------------------------------------
	// Option field layout
	// ------------------------------------------------------------------
	localparam int RATIO_LSB  = 0;
	localparam int RATIO_W    = 3;
	localparam int ASSIGN_BIT = 3;
	localparam int EDGE_BIT   = 4;
	localparam int SOURCE_BIT = 5;
	localparam int SCALER_W   = 8;
	localparam int PHASE_W    = 2;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] OPTION_RST = 8'hff;
	localparam logic [7:0] SCALER_RST = 8'h00;
	localparam logic [7:0] COUNT_RST  = 8'h00;
	localparam logic [1:0] PHASE_RST  = 2'h0;

	// Phase codes inside one instruction cycle: four ref_clk periods
	localparam logic [1:0] PH_ONE  = 2'h0;
	localparam logic [1:0] PH_TWO  = 2'h1;
	localparam logic [1:0] PH_FOUR = 2'h3;

	// Owner of the scaler
	typedef enum logic {SPS_OWN_TIMER, SPS_OWN_WDOG} sps_owner_t;

	// Decoded option bits
	typedef struct packed {
		logic       count_source_sel;
		logic       count_edge_sel;
		logic       scaler_assign_sel;
		logic [2:0] scale_ratio_sel;
	} sps_option_t;

	// Status carried out of the block
	typedef struct packed {
		logic timer_tick;
		logic wdog_tick;
		logic sync_edge;
	} sps_status_t;

endpackage : sps_pkg

// ===== hw/sps_ripple.sv
// Module: 8-bit scaler counter with ratio tap select
`timescale 1ns/1ps
`default_nettype none
module sps_ripple (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       clk_in,
	input  wire logic       clear,
	input  wire logic [2:0] tap_sel,
	output logic            tap_out
);
	logic [sps_pkg::SCALER_W-1:0] cnt_reg;
	logic [sps_pkg::SCALER_W-1:0] cnt_next;
	logic                         in_reg;
	logic                         in_next;
	logic                         rise;

	// ------------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------------
	// Ripple stages modelled as a synchronous rise-counted divider;
	// each stage still toggles once per two edges, so outputs are symmetrical.
	always_comb begin
		in_next  = clk_in;
		rise     = clk_in & ~in_reg;
		cnt_next = cnt_reg;
		if (clear) begin
			cnt_next = sps_pkg::SCALER_RST;
		end else if (rise) begin
			cnt_next = cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= sps_pkg::SCALER_RST;
			in_reg  <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			in_reg  <= in_next;
		end
	end

	assign tap_out = cnt_reg[tap_sel];

	chk_clear_zeroes: assert property (@(posedge ref_clk) disable iff (rst)
		clear |=> cnt_reg == 8'h00) else $error("Scaler not cleared");
endmodule : sps_ripple
`default_nettype wire

// ===== hw/sps_top.sv
// Module: shared scaler with external count synchroniser
//
// Notes on behaviour
// - Scaler output sampled on phase two and phase four before count advances.
// - Timer unscaled: external input passes straight to the synchroniser.
// - Timer scaled: input divided by ripple counter giving symmetrical output.
// - Count advances only after the synchronised edge is captured.
// - One 8-bit scaler serves timer or watchdog.
// - Scaler exclusive: the unowning side runs unscaled.
// - Assign bit and three ratio bits in option low nibble set owner, ratio.
// - Count register writes clear the scaler when timer owns it.
// - Watchdog clear clears scaler when watchdog owns it.
// - Scaler neither readable nor writable; only cleared.
// - Assignment may change at any time.
// - Assign bit zero gives timer, one gives watchdog.
// - Timer ratios 1:2 to 1:256 by powers of two.
// - Counter mode counts input edges; edge bit zero rising, one falling.
`timescale 1ns/1ps
`default_nettype none
module sps_top (
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	input  wire logic                 ext_count_input,
	input  wire logic                 wdog_base_tick,
	input  wire logic                 option_wr,
	input  wire logic [7:0]           option_wdata,
	input  wire logic                 count_wr,
	input  wire logic [7:0]           count_wdata,
	input  wire logic                 watchdog_clear_instr,
	output logic      [7:0]           count_register,
	output logic                      wdog_tick,
	output sps_pkg::sps_option_t      option_out,
	output sps_pkg::sps_status_t      status_out
);
	// ------------------------------------------------------------------
	// Option register and phase counter
	// ------------------------------------------------------------------
	logic [7:0] option_reg;
	logic [7:0] option_next;
	logic [1:0] phase_reg;
	logic [1:0] phase_next;
	sps_pkg::sps_option_t opt;
	sps_pkg::sps_owner_t  owner;
	logic phase_two;
	logic phase_four;

	always_comb begin
		option_next = option_reg;
		if (option_wr) begin
			option_next = option_wdata;
		end
		phase_next = phase_reg + 2'h1;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			option_reg <= sps_pkg::OPTION_RST;
			phase_reg  <= sps_pkg::PHASE_RST;
		end else begin
			option_reg <= option_next;
			phase_reg  <= phase_next;
		end
	end

	assign opt.count_source_sel  = option_reg[sps_pkg::SOURCE_BIT];
	assign opt.count_edge_sel    = option_reg[sps_pkg::EDGE_BIT];
	assign opt.scaler_assign_sel = option_reg[sps_pkg::ASSIGN_BIT];
	assign opt.scale_ratio_sel   = option_reg[sps_pkg::RATIO_LSB +: sps_pkg::RATIO_W];
	assign owner      = opt.scaler_assign_sel ? sps_pkg::SPS_OWN_WDOG
		: sps_pkg::SPS_OWN_TIMER;
	assign phase_two  = (phase_reg == sps_pkg::PH_TWO);
	assign phase_four = (phase_reg == sps_pkg::PH_FOUR);

	// ------------------------------------------------------------------
	// Source select and shared scaler
	// ------------------------------------------------------------------
	logic timer_src;
	logic inst_tick;
	logic scaler_in;
	logic scaler_clr;
	logic tap;
	logic tap_d_reg;
	logic tap_d_next;
	logic scaled_tick;

	// Internal source high over phases one and two, low over three and four;
	// a one-phase pulse would slip between the phase samples and never count
	assign inst_tick = ~phase_reg[1];
	// Edge bit inverts the pin so a falling edge becomes a rising one
	assign timer_src = opt.count_source_sel ?
		(ext_count_input ^ opt.count_edge_sel) : inst_tick;
	assign scaler_in = (owner == sps_pkg::SPS_OWN_TIMER) ? timer_src
		: wdog_base_tick;
	assign scaler_clr = ((owner == sps_pkg::SPS_OWN_TIMER) && count_wr)
		|| ((owner == sps_pkg::SPS_OWN_WDOG) && watchdog_clear_instr);

	// Timer taps bit n (1:2..1:256); watchdog 1:1 at code 0 uses no stage
	logic [2:0] wd_tap;
	assign wd_tap = opt.scale_ratio_sel - 3'h1;

	sps_ripple u_scaler (
		.ref_clk (ref_clk),
		.rst     (rst),
		.clk_in  (scaler_in),
		.clear   (scaler_clr),
		.tap_sel ((owner == sps_pkg::SPS_OWN_TIMER) ? opt.scale_ratio_sel : wd_tap),
		.tap_out (tap)
	);

	always_comb begin
		tap_d_next  = tap;
		scaled_tick = tap & ~tap_d_reg;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tap_d_reg <= 1'b0;
		end else begin
			tap_d_reg <= tap_d_next;
		end
	end

	// ------------------------------------------------------------------
	// Phase synchroniser and count register
	// ------------------------------------------------------------------
	logic pre_out;
	logic samp_q2_reg;
	logic samp_q2_next;
	logic samp_q4_reg;
	logic samp_q4_next;
	logic samp_old_reg;
	logic samp_old_next;
	logic sync_edge;
	logic [7:0] count_next;
	logic wdog_next;
	sps_pkg::sps_status_t status_next;

	// Unscaled timer path bypasses the divider entirely
	assign pre_out = (owner == sps_pkg::SPS_OWN_TIMER) ? tap : timer_src;

	always_comb begin
		samp_q2_next  = samp_q2_reg;
		samp_q4_next  = samp_q4_reg;
		samp_old_next = samp_old_reg;
		// Two samples per instruction cycle, so a two-period level is never missed
		if (phase_two || phase_four) begin
			samp_q2_next = pre_out;
			samp_q4_next = samp_q2_reg;
		end
		if (phase_four) begin
			samp_old_next = samp_q4_reg;
		end
		// Edge seen only once two samples differ, a few phases after the pin
		sync_edge  = (phase_two | phase_four) & samp_q2_reg & ~samp_q4_reg;
		count_next = count_register;
		if (count_wr) begin
			count_next = count_wdata;
		end else if (sync_edge) begin
			count_next = count_register + 8'h01;
		end
		// Watchdog code 000 is 1:1, so no divider stage is tapped
		wdog_next = ((owner == sps_pkg::SPS_OWN_WDOG) && (opt.scale_ratio_sel != 3'h0))
			? scaled_tick : wdog_base_tick;
		status_next.timer_tick = sync_edge;
		status_next.wdog_tick  = wdog_next;
		status_next.sync_edge  = sync_edge;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			samp_q2_reg    <= 1'b0;
			samp_q4_reg    <= 1'b0;
			samp_old_reg   <= 1'b0;
			count_register <= sps_pkg::COUNT_RST;
			wdog_tick      <= 1'b0;
			option_out     <= '1;
			status_out     <= '0;
		end else begin
			samp_q2_reg    <= samp_q2_next;
			samp_q4_reg    <= samp_q4_next;
			samp_old_reg   <= samp_old_next;
			count_register <= count_next;
			wdog_tick      <= wdog_next;
			option_out     <= opt;
			status_out     <= status_next;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence s_edge_seen;
		(phase_two || phase_four) && samp_q2_reg && !samp_q4_reg && !count_wr;
	endsequence

	chk_count_advance: assert property (@(posedge ref_clk) disable iff (rst)
		s_edge_seen |=> count_register == $past(count_register) + 8'h01)
		else $error("Count did not advance on synced edge");

	chk_count_hold: assert property (@(posedge ref_clk) disable iff (rst)
		(!phase_two && !phase_four && !count_wr) |=> $stable(count_register))
		else $error("Count moved outside sample phases");

	chk_q2_sample: assert property (@(posedge ref_clk) disable iff (rst)
		phase_two |=> samp_q2_reg == $past(pre_out))
		else $error("Phase two sample missed");

	chk_bypass_path: assert property (@(posedge ref_clk) disable iff (rst)
		(owner == sps_pkg::SPS_OWN_WDOG) |-> pre_out == timer_src)
		else $error("Unscaled timer path not direct");

	chk_wd_clear: assert property (@(posedge ref_clk) disable iff (rst)
		(watchdog_clear_instr && owner == sps_pkg::SPS_OWN_WDOG) |-> scaler_clr)
		else $error("Watchdog clear did not clear scaler");

	chk_wr_clear: assert property (@(posedge ref_clk) disable iff (rst)
		(count_wr && owner == sps_pkg::SPS_OWN_TIMER) |-> scaler_clr)
		else $error("Count write did not clear scaler");

	chk_no_cross_clr: assert property (@(posedge ref_clk) disable iff (rst)
		(count_wr && !watchdog_clear_instr && owner == sps_pkg::SPS_OWN_WDOG) |-> !scaler_clr)
		else $error("Count write cleared watchdog scaler");

	chk_owner_decode: assert property (@(posedge ref_clk) disable iff (rst)
		option_wr |=> (owner == sps_pkg::SPS_OWN_WDOG) == $past(option_wdata[3]))
		else $error("Assign bit decode wrong");

	chk_wd_unscaled: assert property (@(posedge ref_clk) disable iff (rst)
		(owner == sps_pkg::SPS_OWN_TIMER) |=> wdog_tick == $past(wdog_base_tick))
		else $error("Watchdog tick scaled while timer owns scaler");

	// ------------------------------------------------------------------
	// Further checks
	// ------------------------------------------------------------------
	// Code 000 under the watchdog must not wait on any divider stage
	chk_wd_ratio_one: assert property (@(posedge ref_clk) disable iff (rst)
		(owner == sps_pkg::SPS_OWN_WDOG && opt.scale_ratio_sel == 3'h0)
		|=> wdog_tick == $past(wdog_base_tick))
		else $error("Watchdog ratio one not direct");

	chk_sample_hold: assert property (@(posedge ref_clk) disable iff (rst)
		(!phase_two && !phase_four) |=> $stable(samp_q2_reg))
		else $error("Sample moved outside sample phases");

	chk_edge_select: assert property (@(posedge ref_clk) disable iff (rst)
		opt.count_source_sel |-> timer_src == (ext_count_input ^ opt.count_edge_sel))
		else $error("Edge select not applied");

	chk_option_load: assert property (@(posedge ref_clk) disable iff (rst)
		option_wr |=> option_reg == $past(option_wdata))
		else $error("Option write not taken");

	chk_phase_step: assert property (@(posedge ref_clk) disable iff (rst)
		1'b1 |=> phase_reg == $past(phase_reg) + 2'h1)
		else $error("Phase counter skipped");

	chk_status_copy: assert property (@(posedge ref_clk) disable iff (rst)
		1'b1 |=> status_out.sync_edge == $past(sync_edge))
		else $error("Status edge not registered");
endmodule : sps_top
`default_nettype wire

// ===== verification/sps_ext_src.sv
// External count source model driving the count pin
`timescale 1ns/1ps
`default_nettype none
module sps_ext_src (
	input  wire logic       ref_clk,
	input  wire logic       start,
	input  wire logic [7:0] half_cyc,
	input  wire logic [9:0] pulses,
	output logic            pin,
	output logic            busy
);
	int unsigned left;
	int unsigned cnt;
	initial begin
		pin = 1'b0;
		busy = 1'b0;
	end
	// Caller picks half_cyc: 2 or more unscaled, period 4 or more scaled
	always @(posedge ref_clk) begin
		if (!busy && start) begin
			busy <= 1'b1;
			left <= 2 * pulses;
			cnt <= half_cyc;
		end else if (busy && cnt > 1) begin
			cnt <= cnt - 1;
		end else if (busy && left == 0) begin
			busy <= 1'b0;
		end else if (busy) begin
			pin <= ~pin;
			left <= left - 1;
			cnt <= half_cyc;
		end
	end
endmodule : sps_ext_src
`default_nettype wire

// ===== verification/sps_top_test.sv
// Testbench for the shared scaler and count synchroniser
`timescale 1ns/1ps
`default_nettype none
module sps_top_test;
	logic                 ref_clk;
	logic                 rst;
	logic                 pin;
	logic                 wdog_base_tick;
	logic                 option_wr;
	logic [7:0]           option_wdata;
	logic                 count_wr;
	logic [7:0]           count_wdata;
	logic                 watchdog_clear_instr;
	logic [7:0]           count_register;
	logic                 wdog_tick;
	sps_pkg::sps_option_t option_out;
	sps_pkg::sps_status_t status_out;
	logic                 src_start;
	logic [7:0]           src_half;
	logic [9:0]           src_pulses;
	logic                 src_busy;
	logic                 wd_prev;
	int                   mismatches;
	int                   checked;
	int                   rises;
	int                   r0;

	sps_top sps_top_inst (.ref_clk(ref_clk), .rst(rst), .ext_count_input(pin),
		.wdog_base_tick(wdog_base_tick), .option_wr(option_wr), .option_wdata(option_wdata),
		.count_wr(count_wr), .count_wdata(count_wdata),
		.watchdog_clear_instr(watchdog_clear_instr), .count_register(count_register),
		.wdog_tick(wdog_tick), .option_out(option_out), .status_out(status_out));
	sps_ext_src sps_ext_src_inst (.ref_clk(ref_clk), .start(src_start), .half_cyc(src_half),
		.pulses(src_pulses), .pin(pin), .busy(src_busy));

	// ------------------------------------------------------------------
	// Clock and tick monitor
	// ------------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		wd_prev <= wdog_tick;
		if (wdog_tick === 1'b1 && wd_prev === 1'b0) rises <= rises + 1;
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cnt_wr(input logic [7:0] v);
		@(posedge ref_clk);
		count_wdata <= v;
		count_wr <= 1'b1;
		@(posedge ref_clk);
		count_wr <= 1'b0;
	endtask : cnt_wr
	task automatic wd_clr;
		@(posedge ref_clk);
		watchdog_clear_instr <= 1'b1;
		@(posedge ref_clk);
		watchdog_clear_instr <= 1'b0;
	endtask : wd_clr
	// Count write after settling hides spurious edges from the option change
	task automatic set_opt(input logic [7:0] v);
		@(posedge ref_clk);
		option_wdata <= v;
		option_wr <= 1'b1;
		@(posedge ref_clk);
		option_wr <= 1'b0;
		cyc(12);
		chk({2'h0, option_out}, v & 8'h3f);
		cnt_wr(8'h00);
		cyc(12);
	endtask : set_opt
	task automatic send(input logic [7:0] half, input logic [9:0] n);
		int k;
		@(posedge ref_clk);
		src_half <= half;
		src_pulses <= n;
		src_start <= 1'b1;
		@(posedge ref_clk);
		src_start <= 1'b0;
		cyc(1);
		k = 0;
		while (src_busy === 1'b1 && k < 20000) begin
			cyc(1);
			k++;
		end
		cyc(12);
	endtask : send
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			wdog_base_tick <= 1'b1;
			@(posedge ref_clk);
			wdog_base_tick <= 1'b0;
			cyc(3);
		end
		cyc(4);
	endtask : ticks
	task automatic end_sim;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial begin
		{rst, wdog_base_tick, option_wr, count_wr, watchdog_clear_instr, src_start} = 6'h20;
		{option_wdata, count_wdata, src_half, src_pulses} = '0;
		{mismatches, checked, rises} = '0;
		cyc(8);
		rst <= 1'b0;
		cyc(1);
		chk({2'h0, option_out}, 8'h3f);
		// Each ratio: twice the ratio in rising edges gives two tap rises
		for (int i = 0; i < 8; i++) begin
			set_opt(8'h20 | 8'(i));
			send(8'h04, 10'(4 << i));
			chk(count_register, 8'h02);
		end
		set_opt(8'h20);
		send(8'h04, 10'h001);
		cnt_wr(8'h00);
		send(8'h04, 10'h001);
		chk(count_register, 8'h01);
		set_opt(8'h28);
		send(8'h02, 10'h003);
		chk(count_register, 8'h03);
		set_opt(8'h38);
		send(8'h02, 10'h003);
		chk(count_register, 8'h03);
		wd_clr();
		cnt_wr(8'h00);
		set_opt(8'h09);
		wd_clr();
		r0 = rises;
		ticks(1);
		wd_clr();
		ticks(1);
		chk(8'(rises - r0), 8'h02);
		wd_clr();
		r0 = rises;
		ticks(1);
		cnt_wr(8'h00);
		ticks(1);
		chk(8'(rises - r0), 8'h01);
		wd_clr();
		set_opt(8'h08);
		r0 = rises;
		ticks(2);
		chk(8'(rises - r0), 8'h02);
		wd_clr();
		set_opt(8'h00);
		r0 = rises;
		ticks(3);
		chk(8'(rises - r0), 8'h03);
		end_sim();
	end
	initial begin
		cyc(30000);
		mismatches++;
		end_sim();
	end
endmodule : sps_top_test
`default_nettype wire
